/* File: verilog/css_slot_ctrl.sv */
/*
 holds the per-slot session control registers of the two main card slots.
 assumes a serial bus front end hands each decoded byte access over as a one-cycle
 request on mclk; card status inputs come from pins and are synchronised here.
*/
// Contract
// - power-down select 0 drives card clock from divider field; in synchronous mode the code uses divider setting 0 instead.
// - low-voltage 0 gives 5 V when high/low select 1, else 3 V.
// - writing 1 to warm bit starts a warm reset on that slot; the code acts on it only while the start bit is set.
// - warm bit self-clears on card start bit or card silent flag.
// - start write launches activation only if no faults and card present.
// - start bit going to 0 begins deactivation.
// - supply select bits ignore writes while session runs.
// - synchronous mode ignores power-down select writes while session runs.
// - slot 1 control sits at 01h, slot 2 at 02h.
// - low-voltage select 1 gives 1.8 V whatever high/low select says.
// - power-down select 1 drives card clock from power-down mode field.
// - I/O enable 1 connects host line to card line, else both released.
// - card silent flag set when no answer within the answer window.
`timescale 1ns/1ns
`default_nettype none
`include "css_slot_regs.svh"

module css_slot_ctrl
  import css_pkg::*;
#(
  parameter int ATR_WAIT_CYCLES = 40000
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire css_acc_t         acc_req,
  output logic [7:0]            acc_rdata,
  output logic                  acc_rvalid,
  input  wire logic [1:0]       supply_fault_flag,
  input  wire logic [1:0]       protection_fault_flag,
  input  wire logic [1:0]       card_present_flag,
  input  wire logic [1:0]       card_start_bit_seen,
  input  wire logic [1:0]       sync_card_mode,
  output logic [1:0]            card_clk,
  output logic [1:0][1:0]       vcc_level,
  output logic [1:0]            io_path_connect,
  output logic [1:0]            activate_pulse,
  output logic [1:0]            deactivate_pulse,
  output logic [1:0]            warm_reset_pulse,
  output logic [1:0]            warm_busy,
  output logic [1:0]            card_silent_flag,
  output logic [1:0]            card_reset_level,
  output logic                  aux_contact_eight,
  output logic                  aux_contact_four,
  output logic                  detect_switch_type
);

  localparam int ATR_W = $clog2(ATR_WAIT_CYCLES + 1);

  if (ATR_WAIT_CYCLES < 1) begin : g_bad_atr
    $error("ATR_WAIT_CYCLES must be at least 1");
  end

  function automatic logic [3:0] div_half(input logic [1:0] sel);
    logic [3:0] h;
    h = 4'h1;
    unique case (sel)
      2'h0: h = 4'h1;
      2'h1: h = 4'h2;
      2'h2: h = 4'h4;
      2'h3: h = 4'h5;
    endcase
    return h;
  endfunction

  function automatic logic [1:0] vcc_code(input css_ctrl_t c);
    logic [1:0] v;
    v = c.high_low_voltage_select ? `CSS_VCC_5V : `CSS_VCC_3V;
    if (c.low_voltage_select) begin
      v = `CSS_VCC_1V8;
    end
    return v;
  endfunction

  // pin synchronisers, first stage read only by second
  logic [4:0][1:0] pin_meta_reg;
  logic [4:0][1:0] pin_sync_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {sync_card_mode, card_start_bit_seen, card_present_flag,
                       protection_fault_flag, supply_fault_flag};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  logic [1:0] s_supply_fault_flag;
  logic [1:0] s_protection_fault_flag;
  logic [1:0] s_card_present_flag;
  logic [1:0] s_sbit;
  logic [1:0] s_sync;
  assign s_supply_fault_flag = pin_sync_reg[0];
  assign s_protection_fault_flag = pin_sync_reg[1];
  assign s_card_present_flag = pin_sync_reg[2];
  assign s_sbit = pin_sync_reg[3];
  assign s_sync = pin_sync_reg[4];

  // register state
  css_ctrl_t [1:0]        ctrl_reg;
  css_ctrl_t [1:0]        ctrl_next;
  css_cfg_t  [1:0]        cfg_reg;
  css_cfg_t  [1:0]        cfg_next;
  logic [1:0][7:0]        data_reg;
  logic [1:0][7:0]        data_next;
  logic [1:0][15:0]       cnt_reg;
  logic [1:0][15:0]       cnt_next;
  logic [1:0][ATR_W-1:0]  atr_reg;
  logic [1:0][ATR_W-1:0]  atr_next;
  logic [1:0]             atr_run_reg;
  logic [1:0]             atr_run_next;
  logic [1:0]             silent_reg;
  logic [1:0]             silent_next;
  logic [1:0]             act_reg;
  logic [1:0]             act_next;
  logic [1:0]             deact_reg;
  logic [1:0]             deact_next;
  logic [1:0]             warmp_reg;
  logic [1:0]             warmp_next;
  logic [7:0]             rdata_reg;
  logic [7:0]             rdata_next;
  logic                   rvalid_reg;
  logic                   rvalid_next;

  always_comb begin
    logic       hit;
    logic       sel;
    logic       locked;
    logic       go;
    logic [7:0] w;
    logic [7:0] mask;
    css_ctrl_t  nc;
    hit = 1'b0;
    sel = 1'b0;
    locked = 1'b0;
    go = 1'b0;
    w = acc_req.wdata;
    mask = 8'h00;
    nc = '0;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    data_next = data_reg;
    cnt_next = cnt_reg;
    atr_next = atr_reg;
    atr_run_next = atr_run_reg;
    silent_next = silent_reg;
    act_next = 2'b00;
    deact_next = 2'b00;
    warmp_next = 2'b00;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    // address decode
    if (acc_req.addr == `CSS_ADDR_SLOT_ONE) begin
      hit = 1'b1;
      sel = 1'b0;
    end else if (acc_req.addr == `CSS_ADDR_SLOT_TWO) begin
      hit = 1'b1;
      sel = 1'b1;
    end
    // answer window and hardware clear of warm request
    for (int i = 0; i < 2; i++) begin
      if (atr_run_reg[i]) begin
        if (s_sbit[i]) begin
          atr_run_next[i] = 1'b0;
        end else if (atr_reg[i] == ATR_W'(ATR_WAIT_CYCLES - 1)) begin
          atr_run_next[i] = 1'b0;
          silent_next[i] = 1'b1;
        end else begin
          atr_next[i] = atr_reg[i] + ATR_W'(1);
        end
      end
      if (s_sbit[i] || silent_reg[i]) begin
        ctrl_next[i].warm = 1'b0;
      end
    end
    // host access
    if (acc_req.valid && !acc_req.write) begin
      rvalid_next = 1'b1;
      rdata_next = 8'h00;
      if (hit && !acc_req.reg_one) begin
        rdata_next = ctrl_reg[sel];
      end else if (hit) begin
        mask = sel ? `CSS_CFG_MASK_TWO : `CSS_CFG_MASK_ONE;
        unique case (ctrl_reg[sel].page)
          `CSS_PAGE_CFG:    rdata_next = cfg_reg[sel] & mask;
          `CSS_PAGE_DATA:   rdata_next = data_reg[sel];
          `CSS_PAGE_CNT_HI: rdata_next = cnt_reg[sel][15:8];
          `CSS_PAGE_CNT_LO: rdata_next = cnt_reg[sel][7:0];
        endcase
      end
    end else if (acc_req.valid && hit && !acc_req.reg_one) begin
      nc = css_ctrl_t'(w);
      locked = ctrl_reg[sel].start;
      ctrl_next[sel].io_path_enable = nc.io_path_enable;
      ctrl_next[sel].page = nc.page;
      if (!locked) begin
        ctrl_next[sel].low_voltage_select = nc.low_voltage_select;
        ctrl_next[sel].high_low_voltage_select = nc.high_low_voltage_select;
      end
      if (!(locked && s_sync[sel])) begin
        ctrl_next[sel].power_down_clock_select = nc.power_down_clock_select;
      end
      if (nc.warm && locked) begin
        ctrl_next[sel].warm = 1'b1;
        warmp_next[sel] = 1'b1;
        silent_next[sel] = 1'b0;
        atr_next[sel] = '0;
        atr_run_next[sel] = 1'b1;
      end
      go = !s_supply_fault_flag[sel] && !s_protection_fault_flag[sel] && s_card_present_flag[sel];
      if (nc.start && !locked && go) begin
        ctrl_next[sel].start = 1'b1;
        act_next[sel] = 1'b1;
        silent_next[sel] = 1'b0;
        atr_next[sel] = '0;
        atr_run_next[sel] = 1'b1;
      end else if (!nc.start && locked) begin
        ctrl_next[sel].start = 1'b0;
        ctrl_next[sel].warm = 1'b0;
        deact_next[sel] = 1'b1;
        atr_run_next[sel] = 1'b0;
      end
    end else if (acc_req.valid && hit) begin
      mask = sel ? `CSS_CFG_MASK_TWO : `CSS_CFG_MASK_ONE;
      unique case (ctrl_reg[sel].page)
        `CSS_PAGE_CFG:    cfg_next[sel] = css_cfg_t'(w & mask);
        `CSS_PAGE_DATA:   data_next[sel] = w;
        `CSS_PAGE_CNT_HI: cnt_next[sel][15:8] = w;
        `CSS_PAGE_CNT_LO: cnt_next[sel][7:0] = w;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
      cfg_reg <= '0;
      data_reg <= '0;
      cnt_reg <= '0;
      atr_reg <= '0;
      atr_run_reg <= 2'b00;
      silent_reg <= 2'b00;
      act_reg <= 2'b00;
      deact_reg <= 2'b00;
      warmp_reg <= 2'b00;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
      atr_reg <= atr_next;
      atr_run_reg <= atr_run_next;
      silent_reg <= silent_next;
      act_reg <= act_next;
      deact_reg <= deact_next;
      warmp_reg <= warmp_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // card clock generation, registered supply code and io path
  logic [1:0][3:0] ccnt_reg;
  logic [1:0][3:0] ccnt_next;
  logic [1:0]      cclk_reg;
  logic [1:0]      cclk_next;
  logic [1:0][1:0] vcc_reg;
  logic [1:0][1:0] vcc_next;
  logic [1:0]      ioc_reg;
  logic [1:0]      ioc_next;

  always_comb begin
    logic       level_mode;
    logic       level;
    logic [3:0] half;
    logic [1:0] div;
    level_mode = 1'b0;
    level = 1'b0;
    half = 4'h1;
    div = 2'h0;
    ccnt_next = ccnt_reg;
    cclk_next = cclk_reg;
    vcc_next = vcc_reg;
    ioc_next = ioc_reg;
    for (int i = 0; i < 2; i++) begin
      level_mode = 1'b0;
      level = 1'b0;
      div = s_sync[i] ? 2'h0 : cfg_reg[i].clock_divider_field;
      half = div_half(div);
      if (ctrl_reg[i].power_down_clock_select) begin
        if (s_sync[i] && ctrl_reg[i].start) begin
          level_mode = 1'b1;
          level = cfg_reg[i].power_down_clock_mode[0];
        end else begin
          unique case (cfg_reg[i].power_down_clock_mode)
            2'h0: level_mode = 1'b1;
            2'h1: begin
              level_mode = 1'b1;
              level = 1'b1;
            end
            2'h2: half = 4'(`CSS_PD_HALF);
            2'h3: half = div_half(div);
          endcase
        end
      end
      if (level_mode) begin
        ccnt_next[i] = 4'h0;
        cclk_next[i] = level;
      end else if (ccnt_reg[i] + 4'h1 >= half) begin
        ccnt_next[i] = 4'h0;
        cclk_next[i] = !cclk_reg[i];
      end else begin
        ccnt_next[i] = ccnt_reg[i] + 4'h1;
      end
      vcc_next[i] = vcc_code(ctrl_reg[i]);
      ioc_next[i] = ctrl_reg[i].io_path_enable;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ccnt_reg <= '0;
      cclk_reg <= 2'b00;
      vcc_reg <= '0;
      ioc_reg <= 2'b00;
    end else begin
      ccnt_reg <= ccnt_next;
      cclk_reg <= cclk_next;
      vcc_reg <= vcc_next;
      ioc_reg <= ioc_next;
    end
  end

  assign acc_rdata = rdata_reg;
  assign acc_rvalid = rvalid_reg;
  assign card_clk = cclk_reg;
  assign vcc_level = vcc_reg;
  assign io_path_connect = ioc_reg;
  assign activate_pulse = act_reg;
  assign deactivate_pulse = deact_reg;
  assign warm_reset_pulse = warmp_reg;
  assign card_silent_flag = silent_reg;
  assign card_reset_level[0] = cfg_reg[0].card_reset_level;
  assign card_reset_level[1] = cfg_reg[1].card_reset_level;
  for (genvar g = 0; g < 2; g++) begin : g_warm
    assign warm_busy[g] = ctrl_reg[g].warm;
  end
  assign aux_contact_eight = cfg_reg[0].aux_contact_eight;
  assign aux_contact_four = cfg_reg[0].aux_contact_four;
  assign detect_switch_type = cfg_reg[1].detect_switch_type;

endmodule
`default_nettype wire

/* File: verilog/css_slot_regs.svh */
/*
 holds offsets, field positions, page codes and timing counts of the card slot control block.
 assumes inclusion by bare name from the package and the design file.
*/
`ifndef CSS_SLOT_REGS_SVH
`define CSS_SLOT_REGS_SVH

// slot addresses
`define CSS_ADDR_SLOT_ONE   8'h01
`define CSS_ADDR_SLOT_TWO   8'h02

// session control byte, bit positions
`define CSS_B_LOW_VOLT      7
`define CSS_B_IO_EN         6
`define CSS_B_PAGE_HI       5
`define CSS_B_PAGE_LO       4
`define CSS_B_POWER_DOWN_CLOCK_SELECT          3
`define CSS_B_HILO          2
`define CSS_B_WARM          1
`define CSS_B_START         0

// page codes
`define CSS_PAGE_CFG        2'h0
`define CSS_PAGE_DATA       2'h1
`define CSS_PAGE_CNT_HI     2'h2
`define CSS_PAGE_CNT_LO     2'h3

// writable bits of the page 00 byte per slot
`define CSS_CFG_MASK_ONE    8'h7f
`define CSS_CFG_MASK_TWO    8'hcf

// supply level codes
`define CSS_VCC_1V8         2'h1
`define CSS_VCC_3V          2'h2
`define CSS_VCC_5V          2'h3

// clock timing: mclk period and internal low-power clock half period
`define CSS_MCLK_NS         40
`define CSS_PD_CLK_NS       240
`define CSS_PD_HALF         (`CSS_PD_CLK_NS / `CSS_MCLK_NS)

`endif

/* File: verilog/css_pkg.sv */
/*
 holds the types of the card slot control block.
 assumes css_slot_regs.svh is reachable on the include path.
*/
`include "css_slot_regs.svh"

package css_pkg;

  typedef struct packed {
    logic       low_voltage_select;
    logic       io_path_enable;
    logic [1:0] page;
    logic       power_down_clock_select;
    logic       high_low_voltage_select;
    logic       warm;
    logic       start;
  } css_ctrl_t;

  typedef struct packed {
    logic       detect_switch_type;
    logic       card_reset_level;
    logic       aux_contact_eight;
    logic       aux_contact_four;
    logic [1:0] power_down_clock_mode;
    logic [1:0] clock_divider_field;
  } css_cfg_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       reg_one;
    logic [7:0] addr;
    logic [7:0] wdata;
  } css_acc_t;

endpackage

/* File: verification/css_slot_ctrl_chk.sv */
/*
 checker of the card slot control block, bound to css_slot_ctrl.
 assumes status pins hold steady for three cycles around a start write.
*/
`timescale 1ns/1ns
`default_nettype none
module css_chk
  import css_pkg::*;
(
  input wire logic            mclk,
  input wire logic            sys_rst,
  input wire css_acc_t        acc_req,
  input wire logic [7:0]      acc_rdata,
  input wire logic            acc_rvalid,
  input wire logic [1:0]      supply_fault_flag,
  input wire logic [1:0]      protection_fault_flag,
  input wire logic [1:0]      card_present_flag,
  input wire logic [1:0]      card_start_bit_seen,
  input wire logic [1:0][1:0] vcc_level,
  input wire logic [1:0]      io_path_connect,
  input wire logic [1:0]      activate_pulse,
  input wire logic [1:0]      deactivate_pulse,
  input wire logic [1:0]      warm_reset_pulse,
  input wire logic [1:0]      warm_busy,
  input wire logic [1:0]      card_silent_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [1:0] session_reg;
  logic [1:0] session_next;
  logic [1:0] ok;
  // session tracked from activate and deactivate pulses
  always_comb begin
    session_next = sys_rst ? 2'b00 : (session_reg | activate_pulse) & ~deactivate_pulse;
  end
  always_ff @(posedge mclk) begin
    session_reg <= session_next;
  end
  assign ok = ~supply_fault_flag & ~protection_fault_flag & card_present_flag;
  sequence one_pulse(sig);
    sig ##1 !sig;
  endsequence
  AST_UNMAPPED: assert property (
    acc_req.valid && !acc_req.write && acc_req.addr != 8'h01 && acc_req.addr != 8'h02
    |=> acc_rvalid && acc_rdata == 8'h00) else $error("unmapped read not zero");
  for (genvar s = 0; s < 2; s++) begin : g_slot
    wire ctrl_wr = acc_req.valid && acc_req.write && !acc_req.reg_one && acc_req.addr == 8'(s + 1);
    AST_VCC_SEL: assert property (ctrl_wr && !session_next[s] |-> ##2
      vcc_level[s] ==
      ($past(acc_req.wdata[7], 2) ? 2'h1 : $past(acc_req.wdata[2], 2) ? 2'h3 : 2'h2))
      else $error("supply code wrong");
    AST_VCC_HOLD: assert property (ctrl_wr && session_next[s] |->
      ##2 vcc_level[s] == $past(vcc_level[s], 2)) else $error("supply changed in session");
    AST_START_GO: assert property (ctrl_wr && acc_req.wdata[0] && !session_next[s]
      && ok[s] && $past(ok[s], 1) && $past(ok[s], 2) && $past(ok[s], 3)
      |=> activate_pulse[s]) else $error("no activation");
    AST_START_GATE: assert property ($rose(activate_pulse[s]) |-> $past(ok[s], 3))
      else $error("activation despite fault");
    AST_DEACT: assert property (ctrl_wr && !acc_req.wdata[0] && session_next[s]
      |=> one_pulse(deactivate_pulse[s])) else $error("no deactivation");
    AST_WARM_SET: assert property (ctrl_wr && acc_req.wdata[1:0] == 2'b11
      && session_next[s] |=> warm_busy[s] ##0 one_pulse(warm_reset_pulse[s]))
      else $error("no warm reset");
    AST_WARM_START: assert property (warm_busy[s] && card_start_bit_seen[s] && !ctrl_wr
      |-> ##[1:4] !warm_busy[s]) else $error("warm not cleared by start bit");
    AST_WARM_SILENT: assert property ($rose(card_silent_flag[s]) |=> !warm_busy[s])
      else $error("warm not cleared by silent card");
    AST_IO: assert property (ctrl_wr |-> ##2 io_path_connect[s] == $past(acc_req.wdata[6], 2))
      else $error("io path wrong");
  end
endmodule
bind css_slot_ctrl css_chk css_chk_inst (.mclk, .sys_rst, .acc_req, .acc_rdata, .acc_rvalid,
  .supply_fault_flag, .protection_fault_flag, .card_present_flag, .card_start_bit_seen,
  .vcc_level, .io_path_connect, .activate_pulse, .deactivate_pulse, .warm_reset_pulse,
  .warm_busy, .card_silent_flag);
`default_nettype wire

/* File: verification/css_host.sv */
/*
 host model issuing byte accesses to the slot control block.
 assumes the bench calls acc and mclk runs free.
*/
`timescale 1ns/1ns
`default_nettype none
module css_host
  import css_pkg::*;
(
  input  wire logic       mclk,
  output var  css_acc_t   acc_req,
  input  wire logic [7:0] acc_rdata,
  input  wire logic       acc_rvalid
);
  logic [7:0] shadow [1:2] = '{8'h00, 8'h00};
  initial acc_req = '0;
  task automatic cyc(input logic w, r1, input logic [7:0] a, d, output logic [7:0] rd);
    @(negedge mclk);
    acc_req = '{1'b1, w, r1, a, d};
    @(negedge mclk);
    rd = acc_rvalid ? acc_rdata : 8'hxx;
    acc_req = '{1'b0, ~w, ~r1, ~a, ~d};
    if (w && !r1 && (a == 8'h01 || a == 8'h02))
      shadow[a[1:0]] = d;
  endtask
  // old io path off before the new one goes on
  task automatic acc(input logic w, r1, input logic [7:0] a, d, output logic [7:0] rd);
    if (w && !r1 && d[6] && (a == 8'h01 || a == 8'h02) && shadow[3 - a[1:0]][6])
      cyc(1'b1, 1'b0, 8'h03 - a, shadow[3 - a[1:0]] & 8'hbd, rd);
    cyc(w, r1, a, d, rd);
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
/*
 self-checking bench of the card slot control block.
 assumes css_host, the checker and the design are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "css_slot_regs.svh"
module testbench
  import css_pkg::*;
;
  logic            mclk, sys_rst;
  css_acc_t        acc_req;
  logic [7:0]      acc_rdata, rd, d;
  logic            acc_rvalid;
  logic [1:0]      supply_fault_flag, protection_fault_flag, card_present_flag;
  logic [1:0]      card_start_bit_seen, sync_card_mode, card_clk, io_path_connect;
  logic [1:0]      activate_pulse, deactivate_pulse, warm_reset_pulse, warm_busy;
  logic [1:0]      card_silent_flag, card_reset_level;
  logic            aux_contact_eight, aux_contact_four, detect_switch_type;
  logic [1:0][1:0] vcc_level;
  logic [7:0]      pg_exp [0:3];
  int              fail_count, checked, h;

  css_slot_ctrl #(.ATR_WAIT_CYCLES(20)) css_slot_ctrl_inst (.mclk, .sys_rst, .acc_req,
    .acc_rdata, .acc_rvalid, .supply_fault_flag, .protection_fault_flag, .card_present_flag,
    .card_start_bit_seen, .sync_card_mode, .card_clk, .vcc_level, .io_path_connect,
    .activate_pulse, .deactivate_pulse, .warm_reset_pulse, .warm_busy, .card_silent_flag,
    .card_reset_level, .aux_contact_eight, .aux_contact_four, .detect_switch_type);
  css_host css_host_inst (.mclk, .acc_req, .acc_rdata, .acc_rvalid);

  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  function automatic int half_exp(input int c);
    return (c == 7) ? 1 : (c == 6) ? `CSS_PD_HALF : (c > 3) ? 16 :
           (c == 3) ? 5 : (c == 2) ? 4 : c + 1;
  endfunction
  task automatic check(input string n, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic r1, input logic [7:0] a, dv);
    css_host_inst.acc(1'b1, r1, a, dv, rd);
  endtask
  task automatic rd_is(input string n, input logic r1, input logic [7:0] a, exp);
    css_host_inst.acc(1'b0, r1, a, 8'h00, rd);
    check(n, rd, exp);
  endtask
  // cycles between two card clock edges, 16 when it stands
  task automatic half_of(input int s);
    logic v;
    for (int k = 0; k < 2; k++) begin
      h = 0;
      v = card_clk[s];
      repeat (16) begin
        @(negedge mclk);
        h++;
        if (card_clk[s] !== v) break;
      end
    end
  endtask
  task automatic start_bit(input int s);
    card_start_bit_seen[s] = 1'b1;
    repeat (3) @(negedge mclk);
    card_start_bit_seen[s] = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  initial begin
    void'($urandom(27));
    sys_rst = 1'b1;
    supply_fault_flag = 2'b00;
    protection_fault_flag = 2'b00;
    card_present_flag = 2'b11;
    card_start_bit_seen = 2'b00;
    sync_card_mode = 2'b00;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (3) @(negedge mclk);
    wr(1'b0, 8'h03, 8'hff);
    rd_is("unmapped", 1'b0, 8'h03, 8'h00);
    for (int s = 1; s <= 2; s++) begin
      for (int k = 0; k < 7; k++) begin
        d = (k == 0) ? 8'h84 : (k == 1) ? 8'h44 : 8'($urandom) & 8'hcc;
        wr(1'b0, 8'(s), d);
        rd_is("ctrl", 1'b0, 8'(s), d);
        check("vcc", 8'(vcc_level[s-1]), d[7] ? 8'h01 : d[2] ? 8'h03 : 8'h02);
        check("io", 8'(io_path_connect[s-1]), 8'(d[6]));
      end
      for (int p = 0; p < 4; p++) begin
        d = 8'($urandom);
        wr(1'b0, 8'(s), 8'(p << 4));
        wr(1'b1, 8'(s), d);
        pg_exp[p] = (p != 0) ? d : d & ((s == 1) ? `CSS_CFG_MASK_ONE : `CSS_CFG_MASK_TWO);
      end
      for (int p = 3; p >= 0; p--) begin
        wr(1'b0, 8'(s), 8'(p << 4));
        rd_is("paged", 1'b1, 8'(s), pg_exp[p]);
      end
      check("rst level", 8'(card_reset_level[s-1]), 8'(pg_exp[0][6]));
      d = (s == 1) ? 8'({aux_contact_eight, aux_contact_four}) : 8'(detect_switch_type);
      check("cfg pins", d, (s == 1) ? 8'(pg_exp[0][5:4]) : 8'(pg_exp[0][7]));
      for (int c = 0; c < 8; c++) begin
        wr(1'b0, 8'(s), (c < 4) ? 8'h00 : 8'h08);
        wr(1'b1, 8'(s), (c < 4) ? 8'(c) : 8'((c - 4) << 2));
        half_of(s - 1);
        check("clock half", 8'(h), 8'(half_exp(c)));
        if (c == 4 || c == 5) check("clock level", 8'(card_clk[s-1]), 8'(c - 4));
      end
      for (int k = 0; k < 4; k++) begin
        supply_fault_flag[s-1] = (k == 0);
        protection_fault_flag[s-1] = (k == 1);
        card_present_flag[s-1] = (k != 2);
        repeat (4) @(negedge mclk);
        wr(1'b0, 8'(s), 8'h01);
        start_bit(s - 1);
        rd_is("start", 1'b0, 8'(s), 8'(k == 3));
      end
      check("silent", 8'(card_silent_flag[s-1]), 8'h00);
      wr(1'b0, 8'(s), 8'h85);
      rd_is("supply locked", 1'b0, 8'(s), 8'h01);
      check("vcc locked", 8'(vcc_level[s-1]), 8'h02);
      for (int m = 1; m >= 0; m--) begin
        sync_card_mode[s-1] = 1'(m);
        repeat (4) @(negedge mclk);
        wr(1'b0, 8'(s), 8'h09);
        rd_is("power_down_clock_select", 1'b0, 8'(s), m ? 8'h01 : 8'h09);
      end
      sync_card_mode[s-1] = 1'b1;
      repeat (4) @(negedge mclk);
      half_of(s - 1);
      check("sync clock", 8'(h), 8'h10);
      check("sync level", 8'(card_clk[s-1]), 8'h01);
      sync_card_mode[s-1] = 1'b0;
      repeat (4) @(negedge mclk);
      wr(1'b0, 8'(s), 8'h03);
      check("warm", 8'(warm_busy[s-1]), 8'h01);
      start_bit(s - 1);
      check("warm by start", 8'(warm_busy[s-1]), 8'h00);
      wr(1'b0, 8'(s), 8'h03);
      repeat (30) @(negedge mclk);
      check("silent", 8'(card_silent_flag[s-1]), 8'h01);
      check("warm by silent", 8'(warm_busy[s-1]), 8'h00);
      wr(1'b0, 8'(s), 8'h00);
      rd_is("stop", 1'b0, 8'(s), 8'h00);
    end
    wr(1'b0, 8'h01, 8'h40);
    wr(1'b0, 8'h02, 8'h40);
    repeat (2) @(negedge mclk);
    check("one io path", 8'(io_path_connect), 8'h02);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    check("silent reset", 8'(card_silent_flag), 8'h00);
    check("io reset", 8'(io_path_connect), 8'h00);
    rd_is("ctrl reset", 1'b0, 8'h01, 8'h00);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
